// ===== verilog/idot_pkg.sv
// Constants shared by the iris direct-duty and target timing block
package idot_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_DIRECT   = 4'ha;
    localparam logic [3:0]  ADDR_TIMING   = 4'he;
    localparam int          DIRECT_LSB    = 0;
    localparam int          DIRECT_W      = 10;
    localparam int          DIR_BIT       = 9;
    localparam int          ENABLE_BIT    = 10;
    localparam int          DELAY_LSB     = 0;
    localparam int          DELAY_W       = 8;
    localparam int          STEP_LSB      = 8;
    localparam int          STEP_W        = 5;
    localparam logic [9:0]  DIRECT_RST    = 10'h000;
    localparam logic        ENABLE_RST    = 1'b0;
    localparam logic [7:0]  DELAY_RST     = 8'h00;
    localparam logic [4:0]  STEP_RST      = 5'h00;
    // ------------------------------------------------------------
    // PWM divisors per period select
    // ------------------------------------------------------------
    localparam logic [10:0] DIV_0 = 11'd2046;
    localparam logic [10:0] DIV_1 = 11'd1726;
    localparam logic [10:0] DIV_2 = 11'd862;
    localparam logic [10:0] DIV_3 = 11'd574;
    localparam logic [10:0] DIV_4 = 11'd430;
    localparam logic [10:0] DIV_5 = 11'd350;
    localparam logic [10:0] DIV_6 = 11'd286;
    localparam logic [10:0] DIV_7 = 11'd254;
    // ------------------------------------------------------------
    // Timing base: 3.375 MHz ticks derived from sys_clk
    // ------------------------------------------------------------
    localparam int          SYS_CLK_KHZ   = 200000;
    localparam int          BASE_CLK_KHZ  = 3375;
    localparam logic [16:0] DELAY_UNIT    = 17'd270;
    localparam logic [13:0] STEP_UNIT     = 14'd512;
    localparam int          AVG_DEPTH     = 8;
endpackage

// ===== verilog/idot_core.sv
// Iris output stage: direct-duty override, PWM and target timing
`timescale 1ns/1ps

// Behaviour
// - Enable bit resets to 0; 0 selects loop duty, 1 selects direct value
// - While enabled the PWM runs at the 10-bit direct value's duty
// - Top bit of the duty value is direction, low nine bits magnitude
// - Direction 0 drives coil b to a; direction 1 drives a to b
// - Numerator is magnitude bits 8:1, two zeros, then bit 0; duty a/b
// - Divisor follows period select: 2046 1726 862 574 430 350 286 254
// - Numerator at or above divisor is full on; zero magnitude is off
// - Target loads n*270 base ticks after sync rise; zero loads at once
// - Average advances one step every n*512+1 base ticks
// - Depth select 0 averages eight samples, settling in eight steps
module idot_core
#(
    parameter int SYS_KHZ  = idot_pkg::SYS_CLK_KHZ,
    parameter int BASE_KHZ = idot_pkg::BASE_CLK_KHZ
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic [2:0]  pwm_period_sel,
    input  wire logic [9:0]  loop_duty,
    input  wire logic        video_sync_in,
    input  wire logic [9:0]  target_in,
    input  wire logic        average_depth_select,
    output logic      [9:0]  iris_setpoint_value,
    output logic      [9:0]  iris_target_avg,
    output logic             iris_coil_out_a,
    output logic             iris_coil_out_b
);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [9:0]  direct_duty_value_q;
    logic        direct_en_q;
    logic [7:0]  target_load_delay_q;
    logic [4:0]  avg_step_q;
    logic [15:0] rdata_q;

    wire         wr_direct = reg_wr && (reg_addr == idot_pkg::ADDR_DIRECT);
    wire         wr_timing = reg_wr && (reg_addr == idot_pkg::ADDR_TIMING);
    wire  [15:0] rd_direct = {5'h00, direct_en_q, direct_duty_value_q};
    wire  [15:0] rd_timing = {3'h0, avg_step_q, target_load_delay_q};
    wire  [15:0] rd_mux    =
        (reg_addr == idot_pkg::ADDR_DIRECT) ? rd_direct :
        (reg_addr == idot_pkg::ADDR_TIMING) ? rd_timing : 16'h0000;

    // Values are held whatever the enable says
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            direct_duty_value_q <= idot_pkg::DIRECT_RST;
            direct_en_q         <= idot_pkg::ENABLE_RST;
            target_load_delay_q <= idot_pkg::DELAY_RST;
            avg_step_q          <= idot_pkg::STEP_RST;
            rdata_q             <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (wr_direct)
            begin
                direct_duty_value_q <= reg_wdata[9:0];
                direct_en_q         <= reg_wdata[idot_pkg::ENABLE_BIT];
            end
            if (wr_timing)
            begin
                target_load_delay_q <= reg_wdata[7:0];
                avg_step_q          <= reg_wdata[12:8];
            end
            if (reg_rd)
                rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Duty source, numerator and divisor
    // ------------------------------------------------------------
    logic [10:0] divisor;
    wire  [9:0]  sel_duty = direct_en_q ? direct_duty_value_q
                                        : loop_duty;
    wire         sel_dir  = sel_duty[idot_pkg::DIR_BIT];
    wire  [8:0]  sel_mag  = sel_duty[8:0];
    wire  [10:0] numer    = {sel_mag[8:1], 2'b00, sel_mag[0]};

    always_comb
    begin
        case (pwm_period_sel)
            3'h0:    divisor = idot_pkg::DIV_0;
            3'h1:    divisor = idot_pkg::DIV_1;
            3'h2:    divisor = idot_pkg::DIV_2;
            3'h3:    divisor = idot_pkg::DIV_3;
            3'h4:    divisor = idot_pkg::DIV_4;
            3'h5:    divisor = idot_pkg::DIV_5;
            3'h6:    divisor = idot_pkg::DIV_6;
            3'h7:    divisor = idot_pkg::DIV_7;
            default: divisor = idot_pkg::DIV_0;
        endcase
    end

    // ------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------
    logic [10:0] pwm_cnt_q;
    logic        pwm_on_q;
    logic        out_a_q;
    logic        out_b_q;

    // Shrinking the period mid-cycle must not leave the counter stuck
    wire         pwm_wrap = (pwm_cnt_q >= divisor - 11'd1);
    wire  [10:0] pwm_cnt_d = pwm_wrap ? 11'd0 : pwm_cnt_q + 11'd1;
    // Compare against the count: a>=b stays high all period
    wire         pwm_on_d  = (pwm_cnt_q < numer);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pwm_cnt_q <= 11'd0;
            pwm_on_q  <= 1'b0;
            out_a_q   <= 1'b0;
            out_b_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            pwm_cnt_q <= pwm_cnt_d;
            pwm_on_q  <= pwm_on_d;
            out_a_q   <= pwm_on_d && sel_dir;
            out_b_q   <= pwm_on_d && !sel_dir;
        end
    end
    assign iris_coil_out_a = out_a_q;
    assign iris_coil_out_b = out_b_q;

    // ------------------------------------------------------------
    // Base tick from fractional accumulator
    // ------------------------------------------------------------
    localparam logic [17:0] ACC_STEP = 18'(BASE_KHZ);
    localparam logic [17:0] ACC_MOD  = 18'(SYS_KHZ);
    logic [17:0] acc_q;
    // Exact average rate; tick spacing jitters by one cycle
    wire  [17:0] acc_sum  = acc_q + ACC_STEP;
    wire         base_tick = (acc_sum >= ACC_MOD);
    wire  [17:0] acc_d    = base_tick ? acc_sum - ACC_MOD : acc_sum;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            acc_q <= 18'd0;
        else if (clk_en)
            acc_q <= acc_d;
    end

    // ------------------------------------------------------------
    // Target load delay after sync rise
    // ------------------------------------------------------------
    logic        vd_q;
    logic [16:0] dly_cnt_q;
    logic        dly_arm_q;
    logic [9:0]  setpoint_q;

    wire         vd_rise   = video_sync_in && !vd_q;
    wire  [16:0] dly_len   = 17'(target_load_delay_q * idot_pkg::DELAY_UNIT);
    wire         dly_zero  = (target_load_delay_q == 8'h00);
    wire         dly_done  = dly_arm_q && base_tick && (dly_cnt_q == 17'd1);
    wire         load_now  = (vd_rise && dly_zero) || dly_done;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            vd_q       <= 1'b0;
            dly_cnt_q  <= 17'd0;
            dly_arm_q  <= 1'b0;
            setpoint_q <= 10'h000;
        end
        else if (clk_en)
        begin
            vd_q <= video_sync_in;
            if (vd_rise)
            begin
                dly_cnt_q <= dly_len;
                dly_arm_q <= !dly_zero;
            end
            else if (dly_arm_q && base_tick)
            begin
                dly_cnt_q <= dly_cnt_q - 17'd1;
                dly_arm_q <= (dly_cnt_q != 17'd1);
            end
            if (load_now)
                setpoint_q <= target_in;
        end
    end
    assign iris_setpoint_value = setpoint_q;

    // ------------------------------------------------------------
    // Moving average of the target
    // ------------------------------------------------------------
    localparam int D = idot_pkg::AVG_DEPTH;
    logic [13:0] step_cnt_q;
    logic [9:0]  hist_q [D];
    logic [12:0] sum8;
    logic [11:0] sum4;
    logic [9:0]  avg_q;

    wire  [13:0] step_len  = {avg_step_q, 9'h000} + 14'd1;
    wire         step_now  = base_tick && (step_cnt_q >= step_len - 14'd1);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            step_cnt_q <= 14'd0;
        else if (clk_en && base_tick)
            step_cnt_q <= step_now ? 14'd0 : step_cnt_q + 14'd1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < D; gi++)
        begin : g_hist
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    hist_q[gi] <= 10'h000;
                else if (clk_en && step_now)
                    hist_q[gi] <= (gi == 0) ? setpoint_q
                                            : hist_q[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    always_comb
    begin
        sum8 = 13'd0;
        sum4 = 12'd0;
        for (int i = 0; i < D; i++)
            sum8 = sum8 + 13'(hist_q[i]);
        for (int i = 0; i < D / 2; i++)
            sum4 = sum4 + 12'(hist_q[i]);
    end

    // Depth select 1 is taken as a four-sample average
    wire  [9:0]  avg_d = average_depth_select ? sum4[11:2]
                                              : sum8[12:3];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            avg_q <= 10'h000;
        else if (clk_en)
            avg_q <= avg_d;
    end
    assign iris_target_avg = avg_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_rise_zero;
        clk_en && vd_rise && dly_zero;
    endsequence

    a_enable_after_reset: assert property (
        $fell(rst) |-> !direct_en_q)
        else $error("enable not cleared by reset");
    a_direct_source: assert property (
        direct_en_q |-> sel_duty == direct_duty_value_q)
        else $error("direct value not selected");
    a_coil_direction: assert property (
        clk_en |=> !(out_a_q && out_b_q) && (out_a_q == (pwm_on_q && $past(sel_dir))))
        else $error("coil direction wrong");
    a_numerator_form: assert property (
        numer[2:1] == 2'b00 && numer[0] == sel_duty[0]
        && numer[10:3] == sel_duty[8:1])
        else $error("numerator layout wrong");
    a_divisor_table: assert property (
        (pwm_period_sel == 3'h2) |-> divisor == 11'd862)
        else $error("divisor for select 2 wrong");
    a_zero_duty_off: assert property (
        (clk_en && sel_mag == 9'h000) |=> !pwm_on_q)
        else $error("zero duty drove coil");
    a_full_on_sat: assert property (
        (clk_en && numer >= divisor) |=> pwm_on_q)
        else $error("saturated duty not full on");
    a_load_no_delay: assert property (
        s_rise_zero |=> setpoint_q == $past(target_in))
        else $error("zero delay did not load target");
    a_step_spacing: assert property (
        (clk_en && step_now) |=> step_cnt_q == 14'd0)
        else $error("step counter not restarted");
    a_direct_held: assert property (
        (clk_en && !wr_direct) |=> $stable(direct_duty_value_q))
        else $error("direct value changed without write");

endmodule

// ===== verif/idot_coil_model.sv
// Iris coil model counting drive cycles in each current direction
`timescale 1ns/1ps

module idot_coil_model
(
    input  wire logic sys_clk,
    input  wire logic meas_en,
    input  wire logic coil_a,
    input  wire logic coil_b,
    output int        hi_a,
    output int        hi_b,
    output int        clash
);
    // ------------------------------------------------------------
    // Drive accounting
    // ------------------------------------------------------------
    // Both legs high would short the bridge, so it is counted apart
    always @(posedge sys_clk)
    begin
        if (!meas_en)
        begin
            hi_a  <= 0;
            hi_b  <= 0;
            clash <= 0;
        end
        else
        begin
            hi_a  <= hi_a + int'(coil_a);
            hi_b  <= hi_b + int'(coil_b);
            clash <= clash + int'(coil_a & coil_b);
        end
    end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the iris direct-duty and target timing block
`timescale 1ns/1ps

module testbench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [2:0]  pwm_period_sel = 3'h0;
    logic [9:0]  loop_duty = 10'h000;
    logic        video_sync_in = 1'b0;
    logic [9:0]  target_in = 10'h000;
    logic [9:0]  iris_setpoint_value;
    logic [9:0]  iris_target_avg;
    logic        iris_coil_out_a;
    logic        iris_coil_out_b;
    logic        meas_en = 1'b0;
    int          hi_a;
    int          hi_b;
    int          clash;
    int          n_errors = 0;
    int          n_checks = 0;
    // Four sys_clk cycles per base tick keeps the long counts short
    localparam int TICK = 4;
    int          bdiv [8] = '{2046, 1726, 862, 574, 430, 350, 286, 254};

    always #2.5 sys_clk = ~sys_clk;

    idot_core #(.BASE_KHZ(50000)) dut_u
    (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .clk_en               (1'b1),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_rdata            (reg_rdata),
        .pwm_period_sel       (pwm_period_sel),
        .loop_duty            (loop_duty),
        .video_sync_in        (video_sync_in),
        .target_in            (target_in),
        .average_depth_select (1'b0),
        .iris_setpoint_value  (iris_setpoint_value),
        .iris_target_avg      (iris_target_avg),
        .iris_coil_out_a      (iris_coil_out_a),
        .iris_coil_out_b      (iris_coil_out_b)
    );

    idot_coil_model coil_u
    (
        .sys_clk (sys_clk),
        .meas_en (meas_en),
        .coil_a  (iris_coil_out_a),
        .coil_b  (iris_coil_out_b),
        .hi_a    (hi_a),
        .hi_b    (hi_b),
        .clash   (clash)
    );

    // ------------------------------------------------------------
    // Comparisons and closing
    // ------------------------------------------------------------
    task automatic chk_val(string nm, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_near(string nm, int exp, int got, int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol)
        begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register port and measurement helpers
    // ------------------------------------------------------------
    task automatic wr(logic [3:0] a, logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(logic [3:0] a, output logic [15:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        @(posedge sys_clk);
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(string nm, logic [3:0] a, logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk_val(nm, exp, d);
    endtask

    // One full period holds exactly min(a,b) high cycles on one leg
    task automatic duty(logic [2:0] sel, logic [9:0] v);
        int b;
        int a;
        int hi;
        b = bdiv[sel];
        a = int'({v[8:1], 2'b00, v[0]});
        hi = (a >= b) ? b : a;
        pwm_period_sel = sel;
        repeat (2100) @(posedge sys_clk);
        #1 meas_en = 1'b1;
        repeat (b) @(posedge sys_clk);
        #1;
        chk_near("coil_a_high", v[9] ? hi : 0, hi_a, 0);
        chk_near("coil_b_high", v[9] ? 0 : hi, hi_b, 0);
        chk_near("coil_clash", 0, clash, 0);
        meas_en = 1'b0;
    endtask

    task automatic wait_chg(logic [9:0] sig_sel, output int n);
        logic [9:0] old;
        old = sig_sel ? iris_target_avg : iris_setpoint_value;
        n = 0;
        while ((sig_sel ? iris_target_avg : iris_setpoint_value) === old
               && n < 3000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask

    task automatic sync_rise();
        video_sync_in = 1'b1;
        @(posedge sys_clk);
        #1 video_sync_in = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd_chk("direct_reg_reset", 4'ha, 16'h0000);
        rd_chk("timing_reg_reset", 4'he, 16'h0000);
        wr(4'ha, 16'hffff);
        rd_chk("direct_reg", 4'ha, 16'h07ff);
        wr(4'he, 16'hffff);
        rd_chk("timing_reg", 4'he, 16'h1fff);
        wr(4'h3, 16'hffff);
        rd_chk("unmapped", 4'h3, 16'h0000);
        $display("test regs done");
    endtask

    task automatic t_direct();
        wr(4'ha, 16'h0480);
        for (int s = 0; s < 8; s++)
            duty(3'(s), 10'h080);
        wr(4'ha, 16'h07ff);
        duty(3'h0, 10'h3ff);
        duty(3'h7, 10'h3ff);
        wr(4'ha, 16'h0600);
        duty(3'h2, 10'h200);
        $display("test direct done");
    endtask

    task automatic t_loop();
        loop_duty = 10'h040;
        wr(4'ha, 16'h0280);
        duty(3'h2, 10'h040);
        rd_chk("direct_kept", 4'ha, 16'h0280);
        $display("test loop done");
    endtask

    task automatic t_target();
        int n;
        wr(4'he, 16'h0000);
        target_in = 10'h155;
        sync_rise();
        chk_val("setpoint_now", 16'h0155, 16'(iris_setpoint_value));
        repeat (8 * TICK + 20) @(posedge sys_clk);
        #1 chk_val("avg_settled", 16'h0155, 16'(iris_target_avg));
        wr(4'he, 16'h0001);
        target_in = 10'h2aa;
        sync_rise();
        wait_chg(10'h0, n);
        chk_near("load_delay", 270 * TICK, n + 1, TICK + 2);
        wr(4'he, 16'h0100);
        target_in = 10'h3f8;
        sync_rise();
        wait_chg(10'h1, n);
        wait_chg(10'h1, n);
        chk_near("step_time", 513 * TICK, n, TICK + 2);
        $display("test target done");
    endtask

    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_regs();
        t_direct();
        t_loop();
        t_target();
        test_done();
    end

    // Expected run is about 41k cycles
    initial
    begin
        #600000;
        n_errors++;
        test_done();
    end
endmodule
